// >>> rtl/can_ctrl_pkg.sv
package can_ctrl_pkg;

  // register indices on the special-function register port
  localparam logic [1:0] MODE_CONTROL_IDX      = 2'h0;
  localparam logic [1:0] MODE_STATUS_IDX       = 2'h1;
  localparam logic [1:0] LINK_ERROR_STATUS_IDX = 2'h2;
  localparam logic [1:0] TX_ERROR_COUNT_IDX    = 2'h3;

  // mode_control field layout
  localparam int REQ_MODE_MSB = 7;
  localparam int REQ_MODE_LSB = 5;
  localparam int ABORT_BIT    = 4;
  localparam int WIN_MSB      = 3;
  localparam int WIN_LSB      = 1;

  // mode_status field layout
  localparam int CUR_MODE_MSB = 7;
  localparam int CUR_MODE_LSB = 5;
  localparam int ICODE_MSB    = 3;
  localparam int ICODE_LSB    = 1;

  // link_error_status bit positions
  localparam int RX0_OVFL_BIT  = 7;
  localparam int RX1_OVFL_BIT  = 6;
  localparam int TX_BOFF_BIT   = 5;
  localparam int TX_PASS_BIT   = 4;
  localparam int RX_PASS_BIT   = 3;
  localparam int TX_WARN_BIT   = 2;
  localparam int RX_WARN_BIT   = 1;
  localparam int ANY_WARN_BIT  = 0;

  // reset values
  localparam logic [7:0] MODE_CONTROL_RST = 8'h80;
  localparam logic [2:0] CUR_MODE_RST     = 3'h4;

  // operating mode codes
  localparam logic [2:0] MODE_NORMAL  = 3'h0;
  localparam logic [2:0] MODE_DISABLE = 3'h1;
  localparam logic [2:0] MODE_LOOP    = 3'h2;
  localparam logic [2:0] MODE_LISTEN  = 3'h3;
  localparam logic [2:0] MODE_CONFIG  = 3'h4;

  // interrupt / window codes, shared so software can copy one into the other
  localparam logic [2:0] CODE_NONE  = 3'h0;
  localparam logic [2:0] CODE_ERR   = 3'h1;
  localparam logic [2:0] CODE_TX_BUF2 = 3'h2;
  localparam logic [2:0] CODE_TX_BUF1 = 3'h3;
  localparam logic [2:0] CODE_TX_BUF0 = 3'h4;
  localparam logic [2:0] CODE_RX_BUF1 = 3'h5;
  localparam logic [2:0] CODE_RX_BUF0 = 3'h6;
  localparam logic [2:0] CODE_WAKE    = 3'h7;

  // one-hot window select: {rx buffer 1, rx buffer 0, tx buffer 2, tx buffer 1, tx buffer 0}
  localparam logic [4:0] WSEL_TX_BUF0 = 5'h01;
  localparam logic [4:0] WSEL_TX_BUF1 = 5'h02;
  localparam logic [4:0] WSEL_TX_BUF2 = 5'h04;
  localparam logic [4:0] WSEL_RX_BUF0 = 5'h08;
  localparam logic [4:0] WSEL_RX_BUF1 = 5'h10;

  // error counter thresholds and steps
  localparam logic [8:0] TX_BOFF_LIMIT = 9'h0FF;
  localparam logic [8:0] PASSIVE_LIMIT = 9'h07F;
  localparam logic [8:0] WARN_LIMIT    = 9'h05F;
  localparam logic [8:0] ERR_STEP      = 9'h008;
  localparam logic [7:0] RECOVERY_RUNS = 8'h80;

endpackage

// >>> rtl/err_status_if.sv
`timescale 1ns/1ps
`default_nettype none
interface err_status_if;
  logic       tx_bus_off;
  logic       tx_passive;
  logic       rx_passive;
  logic       tx_warning;
  logic       rx_warning;
  logic       any_warning;
  logic [7:0] tx_count;
  logic [2:0] irq_code;

  modport counter (output tx_bus_off, tx_passive, rx_passive, tx_warning, rx_warning,
                   any_warning, tx_count);
  modport prio    (output irq_code);
  modport top     (input tx_bus_off, tx_passive, rx_passive, tx_warning, rx_warning,
                   any_warning, tx_count, irq_code);
endinterface
`default_nettype wire

// >>> rtl/error_counters.sv
`timescale 1ns/1ps
`default_nettype none
module error_counters (
  input  wire logic clk_sys_i,
  input  wire logic rstn_i,
  input  wire logic tx_err_i,
  input  wire logic tx_ok_i,
  input  wire logic rx_err_i,
  input  wire logic rx_ok_i,
  input  wire logic recessive_run_i,
  err_status_if.counter st
);
  logic [8:0] tx_count;
  logic [8:0] rx_count;
  logic [7:0] run_count;
  logic       bus_off;

  assign bus_off = tx_count > can_ctrl_pkg::TX_BOFF_LIMIT;

  // transmit count grows past 255 into bus-off, then recovers after idle runs
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      tx_count  <= 9'h000;
      run_count <= 8'h00;
    end else if (bus_off) begin
      if (recessive_run_i) begin
        if (run_count == can_ctrl_pkg::RECOVERY_RUNS - 8'h01) begin
          tx_count  <= 9'h000;
          run_count <= 8'h00;
        end else begin
          run_count <= run_count + 8'h01;
        end
      end
    end else if (tx_err_i) begin
      tx_count <= tx_count + can_ctrl_pkg::ERR_STEP;
    end else if (tx_ok_i && tx_count != 9'h000) begin
      tx_count <= tx_count - 9'h001;
    end
  end

  // receive count stops counting up once it reaches 256, just above 255
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rx_count <= 9'h000;
    end else if (rx_err_i && rx_count < 9'h100) begin
      rx_count <= rx_count + can_ctrl_pkg::ERR_STEP;
    end else if (rx_ok_i && rx_count != 9'h000) begin
      rx_count <= rx_count - 9'h001;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      st.tx_bus_off  <= 1'b0;
      st.tx_passive  <= 1'b0;
      st.rx_passive  <= 1'b0;
      st.tx_warning  <= 1'b0;
      st.rx_warning  <= 1'b0;
      st.any_warning <= 1'b0;
      st.tx_count    <= 8'h00;
    end else begin
      st.tx_bus_off  <= bus_off;
      st.tx_passive  <= tx_count > can_ctrl_pkg::PASSIVE_LIMIT;
      st.rx_passive  <= rx_count > can_ctrl_pkg::PASSIVE_LIMIT;
      st.tx_warning  <= (tx_count > can_ctrl_pkg::WARN_LIMIT)
                        && (tx_count <= can_ctrl_pkg::PASSIVE_LIMIT);
      st.rx_warning  <= (rx_count > can_ctrl_pkg::WARN_LIMIT)
                        && (rx_count <= can_ctrl_pkg::PASSIVE_LIMIT);
      st.any_warning <= ((tx_count > can_ctrl_pkg::WARN_LIMIT)
                         && (tx_count <= can_ctrl_pkg::PASSIVE_LIMIT))
                        || ((rx_count > can_ctrl_pkg::WARN_LIMIT)
                         && (rx_count <= can_ctrl_pkg::PASSIVE_LIMIT));
      st.tx_count    <= tx_count[7:0];
    end
  end
endmodule // error_counters
`default_nettype wire

// >>> rtl/irq_code_encoder.sv
`timescale 1ns/1ps
`default_nettype none
module irq_code_encoder (
  input  wire logic       clk_sys_i,
  input  wire logic       rstn_i,
  input  wire logic [7:0] pending_i,
  err_status_if.prio      st
);
  // pending_i bit n stands for code n; bit 0 is unused
  logic [2:0] next_code;

  always_comb begin
    next_code = can_ctrl_pkg::CODE_NONE;
    for (int i = 1; i < 8; i++) begin
      if (pending_i[i]) begin
        next_code = 3'(i);
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      st.irq_code <= can_ctrl_pkg::CODE_NONE;
    end else begin
      st.irq_code <= next_code;
    end
  end
endmodule // irq_code_encoder
`default_nettype wire

// >>> rtl/can_mode_and_error_status.sv
`timescale 1ns/1ps
`default_nettype none
module can_mode_and_error_status (
  input  wire logic       clk_sys_i,
  input  wire logic       rstn_i,
  // special-function register port
  input  wire logic [1:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // protocol engine side
  input  wire logic       engine_idle_i,
  input  wire logic       rx0_overflow_i,
  input  wire logic       rx1_overflow_i,
  input  wire logic       tx_err_i,
  input  wire logic       tx_ok_i,
  input  wire logic       rx_err_i,
  input  wire logic       rx_ok_i,
  input  wire logic       recessive_run_i,
  input  wire logic       wakeup_irq_flag_i,
  input  wire logic       rx_buf0_irq_i,
  input  wire logic       rx_buf1_irq_i,
  input  wire logic       tx_buf0_irq_i,
  input  wire logic       tx_buf1_irq_i,
  input  wire logic       tx_buf2_irq_i,
  input  wire logic       error_irq_flag_i,
  // control outputs
  output logic      [2:0] engine_mode_o,
  output logic      [2:0] abort_tx_o,
  output logic      [4:0] window_sel_o,
  output logic            sleep_ready_o,
  output logic            tx_bus_off_o
);

  typedef enum logic [2:0] {
    MODE_RUN   = 3'b001,
    MODE_WAIT  = 3'b010,
    MODE_APPLY = 3'b100
  } mode_fsm_e;

  err_status_if st ();

  logic [2:0] requested_op_mode;
  logic       abort_all_tx;
  logic [2:0] window_select;
  logic [2:0] current_op_mode;
  logic [2:0] target_mode;
  logic [2:0] next_target;
  logic       rx_buf0_overflow;
  logic       rx_buf1_overflow;
  logic [7:0] mode_control;
  logic [7:0] mode_status;
  logic [7:0] link_error_status;
  logic [7:0] pending;
  logic [4:0] next_window;
  logic       wr_ctrl;
  logic       wr_link;
  mode_fsm_e  mode_state;

  // register write decode
  always_comb begin
    wr_ctrl = 1'b0;
    wr_link = 1'b0;
    if (reg_wr_i && reg_addr_i == can_ctrl_pkg::MODE_CONTROL_IDX) begin
      wr_ctrl = 1'b1;
    end else if (reg_wr_i && reg_addr_i == can_ctrl_pkg::LINK_ERROR_STATUS_IDX) begin
      wr_link = 1'b1;
    end
  end

  // mode_control: bit 0 has no storage, so writes to it are dropped
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      requested_op_mode <= can_ctrl_pkg::MODE_CONTROL_RST[can_ctrl_pkg::REQ_MODE_MSB:
                                                          can_ctrl_pkg::REQ_MODE_LSB];
      abort_all_tx      <= 1'b0;
      window_select     <= 3'h0;
    end else if (wr_ctrl) begin
      requested_op_mode <= reg_wdata_i[can_ctrl_pkg::REQ_MODE_MSB:can_ctrl_pkg::REQ_MODE_LSB];
      abort_all_tx      <= reg_wdata_i[can_ctrl_pkg::ABORT_BIT];
      window_select     <= reg_wdata_i[can_ctrl_pkg::WIN_MSB:can_ctrl_pkg::WIN_LSB];
    end
  end

  // mode request decode and transition
  always_comb begin
    if (requested_op_mode[2]) begin
      next_target = can_ctrl_pkg::MODE_CONFIG;
    end else begin
      next_target = requested_op_mode;
    end
  end

  // the engine only switches mode while the bus is idle; the reported mode
  // trails the request until that moment so software can poll for it
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      mode_state      <= MODE_RUN;
      target_mode     <= can_ctrl_pkg::CUR_MODE_RST;
      current_op_mode <= can_ctrl_pkg::CUR_MODE_RST;
    end else begin
      case (mode_state)
        MODE_RUN: begin
          if (next_target != current_op_mode) begin
            target_mode <= next_target;
            mode_state  <= MODE_WAIT;
          end
        end
        MODE_WAIT: begin
          if (next_target != target_mode) begin
            target_mode <= next_target;
          end else if (engine_idle_i) begin
            mode_state <= MODE_APPLY;
          end
        end
        MODE_APPLY: begin
          current_op_mode <= target_mode;
          mode_state      <= MODE_RUN;
        end
        default: begin
          mode_state <= MODE_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      engine_mode_o <= can_ctrl_pkg::CUR_MODE_RST;
      sleep_ready_o <= 1'b0;
    end else begin
      engine_mode_o <= current_op_mode;
      sleep_ready_o <= current_op_mode == can_ctrl_pkg::MODE_DISABLE;
    end
  end

  // abort of all pending transmissions
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      abort_tx_o <= 3'h0;
    end else begin
      abort_tx_o <= {3{abort_all_tx}};
    end
  end

  // buffer window mapping; the select is valid whatever bank the core uses
  always_comb begin
    case (window_select)
      can_ctrl_pkg::CODE_TX_BUF0: next_window = can_ctrl_pkg::WSEL_TX_BUF0;
      can_ctrl_pkg::CODE_TX_BUF1: next_window = can_ctrl_pkg::WSEL_TX_BUF1;
      can_ctrl_pkg::CODE_TX_BUF2: next_window = can_ctrl_pkg::WSEL_TX_BUF2;
      can_ctrl_pkg::CODE_RX_BUF1: next_window = can_ctrl_pkg::WSEL_RX_BUF1;
      default:                    next_window = can_ctrl_pkg::WSEL_RX_BUF0;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      window_sel_o <= can_ctrl_pkg::WSEL_RX_BUF0;
    end else begin
      window_sel_o <= next_window;
    end
  end

  // interrupt source code; pending bit index equals window code
  always_comb begin
    pending                             = 8'h00;
    pending[can_ctrl_pkg::CODE_WAKE]    = wakeup_irq_flag_i;
    pending[can_ctrl_pkg::CODE_RX_BUF0] = rx_buf0_irq_i;
    pending[can_ctrl_pkg::CODE_RX_BUF1] = rx_buf1_irq_i;
    pending[can_ctrl_pkg::CODE_TX_BUF0] = tx_buf0_irq_i;
    pending[can_ctrl_pkg::CODE_TX_BUF1] = tx_buf1_irq_i;
    pending[can_ctrl_pkg::CODE_TX_BUF2] = tx_buf2_irq_i;
    pending[can_ctrl_pkg::CODE_ERR]     = error_irq_flag_i;
  end

  irq_code_encoder u_irq_code (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .pending_i (pending),
    .st        (st.prio)
  );

  error_counters u_err_cnt (
    .clk_sys_i       (clk_sys_i),
    .rstn_i          (rstn_i),
    .tx_err_i        (tx_err_i),
    .tx_ok_i         (tx_ok_i),
    .rx_err_i        (rx_err_i),
    .rx_ok_i         (rx_ok_i),
    .recessive_run_i (recessive_run_i),
    .st              (st.counter)
  );

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      tx_bus_off_o <= 1'b0;
    end else begin
      tx_bus_off_o <= st.tx_bus_off;
    end
  end

  // sticky overflow flags: a new overflow beats a clear in the same cycle;
  // software clears by writing zero, a one leaves the flag alone
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rx_buf0_overflow <= 1'b0;
    end else if (rx0_overflow_i) begin
      rx_buf0_overflow <= 1'b1;
    end else if (wr_link && !reg_wdata_i[can_ctrl_pkg::RX0_OVFL_BIT]) begin
      rx_buf0_overflow <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rx_buf1_overflow <= 1'b0;
    end else if (rx1_overflow_i) begin
      rx_buf1_overflow <= 1'b1;
    end else if (wr_link && !reg_wdata_i[can_ctrl_pkg::RX1_OVFL_BIT]) begin
      rx_buf1_overflow <= 1'b0;
    end
  end

  // read-back images
  always_comb begin
    mode_control = {requested_op_mode, abort_all_tx, window_select, 1'b0};
    mode_status  = {current_op_mode, 1'b0, st.irq_code, 1'b0};
    link_error_status = {rx_buf0_overflow, rx_buf1_overflow, st.tx_bus_off,
                         st.tx_passive, st.rx_passive, st.tx_warning,
                         st.rx_warning, st.any_warning};
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_addr_i == can_ctrl_pkg::MODE_CONTROL_IDX) begin
      reg_rdata_o <= mode_control;
    end else if (reg_addr_i == can_ctrl_pkg::MODE_STATUS_IDX) begin
      reg_rdata_o <= mode_status;
    end else if (reg_addr_i == can_ctrl_pkg::LINK_ERROR_STATUS_IDX) begin
      reg_rdata_o <= link_error_status;
    end else begin
      reg_rdata_o <= st.tx_count;
    end
  end

endmodule // can_mode_and_error_status
`default_nettype wire

// >>> dv/can_bus_node_model.sv
`timescale 1ns/1ps
`default_nettype none
module can_bus_node_model (
  input  wire logic clk_sys_i,
  input  wire logic busy_i,
  input  wire logic run_en_i,
  output logic      engine_idle_o,
  output logic      recessive_run_o
);
  // a frame in flight keeps the engine from switching mode
  assign engine_idle_o = !busy_i;
  // one pulse per cycle stands for one run of 11 recessive bits
  always_ff @(posedge clk_sys_i) begin
    recessive_run_o <= run_en_i;
  end
endmodule // can_bus_node_model
`default_nettype wire

// >>> dv/can_mode_and_error_status_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module can_mode_and_error_status_chk (
  input wire logic       clk_sys_i,
  input wire logic       rstn_i,
  input wire logic [1:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       engine_idle_i,
  input wire logic       tx_err_i,
  input wire logic       recessive_run_i,
  input wire logic [2:0] engine_mode_o,
  input wire logic [2:0] abort_tx_o,
  input wire logic [4:0] window_sel_o,
  input wire logic       sleep_ready_o,
  input wire logic       tx_bus_off_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  chk_reset_mode: assert property (disable iff (1'b0) !rstn_i |=> engine_mode_o == 3'h4)
    else $error("mode not configuration after reset");
  chk_abort_all: assert property (abort_tx_o == 3'h0 || abort_tx_o == 3'h7)
    else $error("abort not common to all transmit buffers");
  chk_abort_follow: assert property (reg_wr_i && reg_addr_i == 2'h0 |->
    ##2 abort_tx_o[0] == $past(reg_wdata_i[4], 2))
    else $error("abort output does not follow control write");
  chk_window_onehot: assert property ($onehot(window_sel_o))
    else $error("window select not one buffer");
  chk_ctrl_spare: assert property (reg_rd_i && reg_addr_i == 2'h0 |=> !reg_rdata_o[0])
    else $error("mode control spare bit reads one");
  chk_status_legal: assert property (reg_rd_i && reg_addr_i == 2'h1 |=>
    reg_rdata_o[7:5] <= 3'h4 && !reg_rdata_o[4] && !reg_rdata_o[0])
    else $error("mode status reserved code or spare bit");
  chk_mode_wait: assert property ($changed(engine_mode_o) |-> $past(engine_idle_i, 3))
    else $error("mode changed without idle engine");
  chk_busoff_rise: assert property ($rose(tx_bus_off_o) |-> $past(tx_err_i, 3))
    else $error("bus off set without transmit error");
  chk_busoff_clear: assert property ($fell(tx_bus_off_o) |-> $past(recessive_run_i, 3))
    else $error("bus off cleared without recessive run");

  cov_bus_off: cover property ($rose(tx_bus_off_o));
  cov_sleep: cover property ($rose(sleep_ready_o));
  cov_abort: cover property (abort_tx_o == 3'h7);
endmodule // can_mode_and_error_status_chk

bind can_mode_and_error_status can_mode_and_error_status_chk chk_i (
  .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .engine_idle_i(engine_idle_i), .tx_err_i(tx_err_i),
  .recessive_run_i(recessive_run_i), .engine_mode_o(engine_mode_o),
  .abort_tx_o(abort_tx_o), .window_sel_o(window_sel_o),
  .sleep_ready_o(sleep_ready_o), .tx_bus_off_o(tx_bus_off_o)
);
`default_nettype wire

// >>> dv/can_mode_and_error_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
module can_mode_and_error_status_tb;
  typedef struct packed {
    logic [7:0] pend;
    logic [2:0] code;
    logic [4:0] wsel;
  } row_s;
  logic       clk_sys_i;
  logic       rstn_i;
  logic [1:0] reg_addr_i;
  logic       reg_wr_i;
  logic [7:0] reg_wdata_i;
  logic       reg_rd_i;
  logic [7:0] reg_rdata_o;
  logic       engine_idle;
  logic       ovf0;
  logic       ovf1;
  logic       tx_err;
  logic       tx_ok;
  logic       rx_err;
  logic       rx_ok;
  logic       run;
  logic       busy;
  logic       run_en;
  logic [7:0] pend;
  logic [2:0] engine_mode;
  logic [2:0] abort_tx;
  logic [4:0] window_sel;
  logic       sleep_ready;
  logic       bus_off;
  logic [7:0] d;
  logic [2:0] e;
  int         n_errors;
  int         comparisons;
  int         cycles;
  row_s       rows[8];

  can_mode_and_error_status can_mode_and_error_status_i (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .engine_idle_i(engine_idle), .rx0_overflow_i(ovf0), .rx1_overflow_i(ovf1),
    .tx_err_i(tx_err), .tx_ok_i(tx_ok), .rx_err_i(rx_err), .rx_ok_i(rx_ok),
    .recessive_run_i(run), .wakeup_irq_flag_i(pend[7]), .rx_buf0_irq_i(pend[6]),
    .rx_buf1_irq_i(pend[5]), .tx_buf0_irq_i(pend[4]), .tx_buf1_irq_i(pend[3]),
    .tx_buf2_irq_i(pend[2]), .error_irq_flag_i(pend[1]), .engine_mode_o(engine_mode),
    .abort_tx_o(abort_tx), .window_sel_o(window_sel), .sleep_ready_o(sleep_ready),
    .tx_bus_off_o(bus_off));

  can_bus_node_model can_bus_node_model_i (
    .clk_sys_i(clk_sys_i), .busy_i(busy), .run_en_i(run_en),
    .engine_idle_o(engine_idle), .recessive_run_o(run));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic stop_test;
    if (n_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    reg_addr_i = a;
    reg_wdata_i = v;
    reg_wr_i = 1'b1;
    idle(1);
    reg_wr_i = 1'b0;
    idle(1);
  endtask

  // read data is registered on the taking edge
  task automatic rd(input logic [1:0] a);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    idle(1);
    d = reg_rdata_o;
    reg_rd_i = 1'b0;
    idle(1);
  endtask

  task automatic st(input logic [7:0] v);
    rd(2'h2);
    chk("link status", d, v);
  endtask

  task automatic errs(input logic tx, input int n);
    tx_err = tx;
    rx_err = !tx;
    idle(n);
    tx_err = 1'b0;
    rx_err = 1'b0;
    idle(3);
  endtask

  task automatic oks(input logic tx);
    tx_ok = tx;
    rx_ok = !tx;
    idle(1);
    tx_ok = 1'b0;
    rx_ok = 1'b0;
    idle(3);
  endtask

  task automatic mode_to(input logic [2:0] m);
    int k;
    k = 0;
    rd(2'h1);
    while (d[7:5] !== m && k < 12) begin
      rd(2'h1);
      k++;
    end
  endtask

  task automatic reset_chk;
    rd(2'h0);
    chk("mode control", d, 8'h80);
    rd(2'h1);
    chk("mode status", d, 8'h80);
    st(8'h00);
    chk("window", window_sel, 5'h08);
    chk("abort", abort_tx, 3'h0);
    chk("engine mode", engine_mode, 3'h4);
  endtask

  initial begin
    rows = '{'{8'h00, 3'h0, 5'h08}, '{8'h02, 3'h1, 5'h08}, '{8'h06, 3'h2, 5'h04},
             '{8'h0A, 3'h3, 5'h02}, '{8'h12, 3'h4, 5'h01}, '{8'h22, 3'h5, 5'h10},
             '{8'h42, 3'h6, 5'h08}, '{8'hFE, 3'h7, 5'h08}};
    {reg_addr_i, reg_wr_i, reg_wdata_i, reg_rd_i} = '0;
    {ovf0, ovf1, tx_err, tx_ok, rx_err, rx_ok, busy, run_en, pend} = '0;
    rstn_i = 1'b0;
    idle(8);
    rstn_i = 1'b1;
    reset_chk();
    // copy each interrupt code into the window field
    foreach (rows[i]) begin
      pend = rows[i].pend;
      idle(2);
      rd(2'h1);
      chk("irq code", d, {3'h4, 1'b0, rows[i].code, 1'b0});
      wr(2'h0, {3'h4, 1'b0, d[3:1], 1'b0});
      idle(1);
      chk("window", window_sel, rows[i].wsel);
    end
    pend = '0;
    wr(2'h0, 8'hFF);
    idle(1);
    chk("abort", abort_tx, 3'h7);
    rd(2'h0);
    chk("mode control", d, 8'hFE);
    wr(2'h1, 8'hFF);
    wr(2'h2, 8'h3F);
    wr(2'h3, 8'hFF);
    rd(2'h1);
    chk("status spare", d & 8'h11, 8'h00);
    rd(2'h3);
    chk("tx count", d, 8'h00);
    st(8'h00);
    wr(2'h0, 8'h80);
    idle(1);
    chk("abort", abort_tx, 3'h0);
    {ovf0, ovf1} = 2'b11;
    idle(1);
    {ovf0, ovf1} = 2'b00;
    idle(2);
    st(8'hC0);
    wr(2'h2, 8'hFF);
    st(8'hC0);
    wr(2'h2, 8'h40);
    st(8'h40);
    wr(2'h2, 8'h00);
    st(8'h00);
    // overflow and software clear on one edge: the overflow must win
    {reg_addr_i, reg_wdata_i, reg_wr_i, ovf0} = {2'h2, 8'h00, 1'b1, 1'b1};
    idle(1);
    {reg_wr_i, ovf0} = 2'b00;
    idle(1);
    st(8'h80);
    wr(2'h2, 8'h00);
    st(8'h00);
    errs(1'b1, 11);
    st(8'h00);
    errs(1'b1, 1);
    st(8'h05);
    rd(2'h3);
    chk("tx count", d, 8'h60);
    errs(1'b1, 4);
    st(8'h10);
    oks(1'b1);
    st(8'h05);
    errs(1'b1, 16);
    st(8'h10);
    rd(2'h3);
    chk("tx count", d, 8'hFF);
    errs(1'b1, 1);
    st(8'h30);
    chk("bus off pin", bus_off, 1'b1);
    run_en = 1'b1;
    idle(127);
    run_en = 1'b0;
    idle(4);
    st(8'h30);
    run_en = 1'b1;
    idle(1);
    run_en = 1'b0;
    idle(5);
    st(8'h00);
    chk("bus off pin", bus_off, 1'b0);
    errs(1'b0, 12);
    st(8'h03);
    errs(1'b0, 4);
    st(8'h08);
    oks(1'b0);
    st(8'h03);
    for (int m = 0; m < 8; m++) begin
      e = m[2] ? 3'h4 : m[2:0];
      wr(2'h0, {m[2:0], 5'h00});
      mode_to(e);
      chk("mode", d[7:5], e);
      idle(1);
      chk("engine mode", engine_mode, e);
      chk("sleep ready", sleep_ready, e == 3'h1);
    end
    busy = 1'b1;
    wr(2'h0, 8'h40);
    idle(6);
    rd(2'h1);
    chk("mode held", d[7:5], 3'h4);
    busy = 1'b0;
    mode_to(3'h2);
    chk("mode", d[7:5], 3'h2);
    rstn_i = 1'b0;
    idle(2);
    rstn_i = 1'b1;
    reset_chk();
    stop_test();
  end
endmodule // can_mode_and_error_status_tb
`default_nettype wire
